// [verilog/dcls_ctrl.sv]
// Controller end: local request port toward user, command/data toward PHY
//
// How it works
// - Accept requests until queue full, then drop ready
// - User starts transfer with strobe, size, address
// - User holds request while ready is low
// - Strobe and ready high means accepted
// - Memory column is local column shifted left two
// - Each accepted request becomes a PHY command
// - Write-valid marks cycles carrying write data, masks
// - Strobe-burst framing sets PHY write strobe timing
// - PHY sends command then write data, strobe
// - Read window lasts the expected read burst
// - PHY captures only inside the read window
// - PHY flags each valid resynchronised read word
// - Local read valid marks each returned word
// - Without ECC read data passes with no delay
// - With ECC read data delayed one or three
`timescale 1ns/100ps
module dcls_ctrl #(
   parameter logic [1:0] ECC_MODE = 2'h0
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic write_req_in,
   input wire logic read_req_in,
   input wire logic [dcls_pkg::DCLS_SIZE_W-1:0] size_in,
   input wire logic [dcls_pkg::DCLS_ADDR_W-1:0] addr_in,
   input wire logic [dcls_pkg::DCLS_DATA_W-1:0] wdata_in,
   output logic ready_out,
   output logic rdata_valid_out,
   output logic [dcls_pkg::DCLS_DATA_W-1:0] rdata_out,
   dcls_phy_if.ctrl phy
);
   import dcls_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Last beat of a burst; write and read phases end on the same count
   function automatic logic dcls_last_beat(
      input logic [DCLS_SIZE_W-1:0] left
   );
      return left == DCLS_SIZE_ONE;
   endfunction

   // ----------------------------------------------------------------
   // Command queue
   // ----------------------------------------------------------------
   typedef enum {
      IDLE,
      WRITE,
      READ
   } dcls_state_t;

   dcls_req_t queue [DCLS_QDEPTH];
   logic [DCLS_DATA_W-1:0] wq [DCLS_QDEPTH];
   logic [DCLS_QIDX_W-1:0] wr_ptr;
   logic [DCLS_QIDX_W-1:0] rd_ptr;
   logic [DCLS_QCNT_W-1:0] count;
   logic accept;
   logic pop;
   dcls_state_t state;
   logic [DCLS_SIZE_W-1:0] beats;
   dcls_req_t head;
   logic [DCLS_QCNT_W-1:0] next_count;

   // Request taken when strobe meets ready
   assign accept = ce_in && ready_out && (write_req_in || read_req_in);
   assign head = queue[rd_ptr];
   // Pop only from idle so commands leave strictly in arrival order
   assign pop = ce_in && state == IDLE && count != DCLS_QCNT_ZERO;
   assign next_count = count + DCLS_QCNT_W'(accept) - DCLS_QCNT_W'(pop);

   // Queue storage; in-order issue keeps a read behind an older write
   always_ff @(posedge mclk_in) begin
      if (accept) begin
         queue[wr_ptr] <= '{write_req_in, size_in, addr_in};
         wq[wr_ptr] <= wdata_in;
      end
   end

   // Pointers and fill level
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= DCLS_QCNT_ZERO;
      end else if (ce_in) begin
         if (accept) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
         count <= next_count;
      end
   end

   // Ready registered from next fill level, drops as queue fills
   // Built from the next level so the entry that fills it closes the door
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ready_out <= 1'b0;
      end else if (ce_in) begin
         ready_out <= next_count != DCLS_QCNT_FULL;
      end
   end

   // ----------------------------------------------------------------
   // Issue sequencer
   // ----------------------------------------------------------------
   // Limitation: one command in flight, so a long burst stalls the head;
   // strict order is what keeps a read behind an older write
   // Command, address mapping and data framing toward the PHY
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= IDLE;
         beats <= DCLS_SIZE_ZERO;
         phy.cmd <= DCLS_CMD_NOP;
         phy.row <= '0;
         phy.col <= '0;
         phy.bank <= '0;
         phy.burst <= DCLS_SIZE_ZERO;
         phy.wdata_valid <= 1'b0;
         phy.wdata <= '0;
         phy.wmask <= '0;
         phy.dqs_burst <= 1'b0;
         phy.doing_rd <= 1'b0;
      end else if (ce_in) begin
         phy.cmd <= DCLS_CMD_NOP;
         phy.wdata_valid <= 1'b0;
         phy.dqs_burst <= 1'b0;
         phy.doing_rd <= 1'b0;
         unique case (state)
            IDLE: begin
               if (pop) begin
                  phy.cmd <= head.is_wr ? DCLS_CMD_WR : DCLS_CMD_RD;
                  phy.col <= DCLS_MCOL_W'(head.addr[DCLS_COL_LOCAL_W-1:0])
                     << DCLS_COL_SHIFT;
                  // Row and bank come from the upper local bits
                  phy.row <= head.addr[DCLS_ROW_LSB +: DCLS_ROW_W];
                  phy.bank <= head.addr[DCLS_BANK_LSB +: DCLS_BANK_W];
                  phy.burst <= head.size;
                  beats <= head.size;
                  phy.wdata <= wq[rd_ptr];
                  // Size zero issues a command with no data phase
                  if (head.size != DCLS_SIZE_ZERO)
                     state <= head.is_wr ? WRITE : READ;
               end
            end
            WRITE: begin
               // Same stored word repeats for every beat of the burst
               phy.wdata_valid <= 1'b1;
               phy.wmask <= '1;
               phy.dqs_burst <= 1'b1;
               beats <= beats - 1'b1;
               if (dcls_last_beat(beats)) state <= IDLE;
            end
            READ: begin
               // One window cycle per expected read word
               phy.doing_rd <= 1'b1;
               beats <= beats - 1'b1;
               if (dcls_last_beat(beats)) state <= IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read return with optional ECC latency
   // ----------------------------------------------------------------
   logic vpipe [DCLS_ECC_MAX];
   logic [DCLS_DATA_W-1:0] dpipe [DCLS_ECC_MAX];

   // First stage takes the PHY word; taps picked by ECC_MODE below,
   // trading read latency for room to check and correct the word
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         vpipe[0] <= 1'b0;
         dpipe[0] <= '0;
      end else if (ce_in) begin
         vpipe[0] <= phy.rdata_valid;
         dpipe[0] <= phy.rdata;
      end
   end

   // Later stages each copy the one before; valid travels with data
   for (genvar g = 1; g < DCLS_ECC_MAX; g++) begin : gen_stage
      always_ff @(posedge mclk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            vpipe[g] <= 1'b0;
            dpipe[g] <= '0;
         end else if (ce_in) begin
            vpipe[g] <= vpipe[g-1];
            dpipe[g] <= dpipe[g-1];
         end
      end
   end

   // Local return; no-ECC path is combinational from PHY read data
   // Zero-latency path is not registered; timing runs through PHY flops
   always_comb begin
      rdata_valid_out = phy.rdata_valid;
      rdata_out = phy.rdata;
      if (ECC_MODE == DCLS_ECC_ONE) begin
         rdata_valid_out = vpipe[0];
         rdata_out = dpipe[0];
      end else if (ECC_MODE == DCLS_ECC_THREE) begin
         rdata_valid_out = vpipe[DCLS_ECC_MAX-1];
         rdata_out = dpipe[DCLS_ECC_MAX-1];
      end
   end

endmodule

// [verilog/dcls_pkg.sv]
// Package with constants and types shared by both ends of the sequencer link
package dcls_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DCLS_ADDR_W = 24;
   localparam int DCLS_DATA_W = 32;
   localparam int DCLS_SIZE_W = 3;
   localparam int DCLS_COL_LOCAL_W = 8;
   localparam int DCLS_ROW_W = 14;
   localparam int DCLS_BANK_W = 2;
   localparam int DCLS_MCOL_W = 10;
   localparam int DCLS_QDEPTH = 4;
   localparam int DCLS_QIDX_W = 2;
   localparam int DCLS_QCNT_W = 3;

   // ----------------------------------------------------------------
   // Address mapping and timing constants
   // ----------------------------------------------------------------
   localparam int DCLS_COL_SHIFT = 2;
   localparam int DCLS_ROW_LSB = DCLS_COL_LOCAL_W;
   localparam int DCLS_BANK_LSB = DCLS_COL_LOCAL_W + DCLS_ROW_W;
   localparam int DCLS_ECC_MAX = 3;
   localparam logic [1:0] DCLS_ECC_OFF = 2'h0;
   localparam logic [1:0] DCLS_ECC_ONE = 2'h1;
   localparam logic [1:0] DCLS_ECC_THREE = 2'h3;
   localparam logic [DCLS_QCNT_W-1:0] DCLS_QCNT_ZERO = 3'h0;
   localparam logic [DCLS_QCNT_W-1:0] DCLS_QCNT_FULL = 3'h4;
   localparam logic [DCLS_SIZE_W-1:0] DCLS_SIZE_ZERO = 3'h0;
   localparam logic [DCLS_SIZE_W-1:0] DCLS_SIZE_ONE = 3'h1;
   localparam logic [DCLS_SIZE_W-1:0] DCLS_PHY_RD_LAT = 3'h4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DCLS_CMD_NOP,
      DCLS_CMD_WR,
      DCLS_CMD_RD
   } dcls_cmd_t;

   typedef struct packed {
      logic is_wr;
      logic [DCLS_SIZE_W-1:0] size;
      logic [DCLS_ADDR_W-1:0] addr;
   } dcls_req_t;

endpackage

// [verilog/dcls_phy_if.sv]
// Interface joining the controller end and the PHY end
`timescale 1ns/100ps
interface dcls_phy_if;
   import dcls_pkg::*;
   dcls_cmd_t cmd;
   logic [DCLS_ROW_W-1:0] row;
   logic [DCLS_MCOL_W-1:0] col;
   logic [DCLS_BANK_W-1:0] bank;
   logic [DCLS_SIZE_W-1:0] burst;
   logic wdata_valid;
   logic [DCLS_DATA_W-1:0] wdata;
   logic [3:0] wmask;
   logic dqs_burst;
   logic doing_rd;
   logic rdata_valid;
   logic [DCLS_DATA_W-1:0] rdata;

   modport ctrl (
      output cmd, row, col, bank, burst, wdata_valid, wdata, wmask,
      output dqs_burst, doing_rd,
      input rdata_valid, rdata
   );
   modport phy (
      input cmd, row, col, bank, burst, wdata_valid, wdata, wmask,
      input dqs_burst, doing_rd,
      output rdata_valid, rdata
   );
endinterface

// [verilog/dcls_phy.sv]
// PHY end: takes controller commands, captures and returns read data
`timescale 1ns/100ps
module dcls_phy (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   dcls_phy_if.phy phy,
   input wire logic [dcls_pkg::DCLS_DATA_W-1:0] mem_rdata_in,
   output logic mem_wr_out,
   output logic mem_rd_out,
   output logic [dcls_pkg::DCLS_DATA_W-1:0] mem_wdata_out,
   output logic mem_wdata_en_out,
   output logic mem_dqs_out,
   output logic [dcls_pkg::DCLS_MCOL_W-1:0] mem_col_out
);
   import dcls_pkg::*;

   // ----------------------------------------------------------------
   // Memory side
   // ----------------------------------------------------------------
   logic [DCLS_DATA_W-1:0] rsync1;
   logic [DCLS_DATA_W-1:0] rsync2;
   logic cap;

   // Command first, then data with strobe on following cycles
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mem_wr_out <= 1'b0;
         mem_rd_out <= 1'b0;
         mem_col_out <= '0;
         mem_wdata_out <= '0;
         mem_wdata_en_out <= 1'b0;
         mem_dqs_out <= 1'b0;
      end else if (ce_in) begin
         mem_wr_out <= phy.cmd == DCLS_CMD_WR;
         mem_rd_out <= phy.cmd == DCLS_CMD_RD;
         if (phy.cmd != DCLS_CMD_NOP) mem_col_out <= phy.col;
         mem_wdata_out <= phy.wdata;
         mem_wdata_en_out <= phy.wdata_valid;
         mem_dqs_out <= phy.dqs_burst;
      end
   end

   // Pin data passes two flops before capture logic reads it
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rsync1 <= '0;
         rsync2 <= '0;
      end else if (ce_in) begin
         rsync1 <= mem_rdata_in;
         rsync2 <= rsync1;
      end
   end

   // Capture only inside the read window, fixed PHY latency
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cap <= 1'b0;
         phy.rdata_valid <= 1'b0;
         phy.rdata <= '0;
      end else if (ce_in) begin
         cap <= phy.doing_rd;
         phy.rdata_valid <= cap;
         if (cap) phy.rdata <= rsync2;
      end
   end

endmodule

// [sim/dcls_monitor.sv]
// Checker for the link between the controller end and the PHY end
`timescale 1ns/100ps
module dcls_monitor (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire dcls_pkg::dcls_cmd_t cmd,
   input wire logic [dcls_pkg::DCLS_MCOL_W-1:0] col,
   input wire logic [dcls_pkg::DCLS_SIZE_W-1:0] burst,
   input wire logic wdata_valid,
   input wire logic [3:0] wmask,
   input wire logic dqs_burst,
   input wire logic doing_rd,
   input wire logic rdata_valid
);
   import dcls_pkg::*;
   // One clock domain, so clocking and disable are declared once
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   // ----------------------------------------------------------------
   // Write side and command column
   // ----------------------------------------------------------------
   mask_full_a: assert property (wdata_valid |-> wmask == 4'hf)
      else $error("write mask not fully enabled");
   strobe_frame_a: assert property (wdata_valid |-> dqs_burst)
      else $error("strobe burst missing during write data");
   wr_data_a: assert property (
      cmd == DCLS_CMD_WR && burst == 3'h1 |=> wdata_valid ##1 !wdata_valid)
      else $error("single write beat not framed");
   col_shift_a: assert property (
      cmd != DCLS_CMD_NOP |-> col[1:0] == 2'h0)
      else $error("memory column low bits not clear");
   // ----------------------------------------------------------------
   // Read side
   // ----------------------------------------------------------------
   rd_win_a: assert property (
      cmd == DCLS_CMD_RD && burst == 3'h3 |=> doing_rd[*3] ##1 !doing_rd)
      else $error("read window length wrong");
   rd_open_a: assert property (
      cmd == DCLS_CMD_RD && burst != 3'h0 |=> doing_rd)
      else $error("read window late");
   rvalid_lat_a: assert property (doing_rd |-> ##2 rdata_valid)
      else $error("read valid missing after window");
   rvalid_cause_a: assert property (
      rdata_valid |-> $past(doing_rd, 2))
      else $error("read valid without window");
endmodule

// [sim/tb_dram_ctrl_local_to_phy_sequencing.sv]
// Self-checking bench for the controller and PHY ends joined
`timescale 1ns/100ps
module tb_dram_ctrl_local_to_phy_sequencing;
   import dcls_pkg::*;
   logic mclk_in, resetn_in, ce_in, write_req_in, read_req_in, ready_out;
   logic rdata_valid_out, e3_valid, e1_valid;
   logic mem_wr_out, mem_rd_out, mem_wdata_en_out, mem_dqs_out;
   logic [DCLS_MCOL_W-1:0] mem_col_out;
   logic [DCLS_SIZE_W-1:0] size_in;
   logic [DCLS_ADDR_W-1:0] addr_in;
   logic [DCLS_DATA_W-1:0] wdata_in, mem_rdata_in, rdata_out, e3_rdata;
   logic [DCLS_DATA_W-1:0] e1_rdata, mem_wdata_out;
   int error_cnt = 0, n_checks = 0, cyc = 0, stalls = 0, rd_win = 0;
   logic [27:0] cmd_q[$];
   logic [10:0] mc_q[$];
   logic [31:0] wd_q[$], mw_q[$];
   logic [63:0] rv_q[$], e3_q[$], e1_q[$];
   dcls_phy_if phy();
   dcls_phy_if phy_e3();
   dcls_phy_if phy_e1();
   dcls_ctrl dcls_ctrl_i (.mclk_in, .resetn_in, .ce_in, .write_req_in,
      .read_req_in, .size_in, .addr_in, .wdata_in, .ready_out,
      .rdata_valid_out, .rdata_out, .phy(phy));
   dcls_phy dcls_phy_i (.mclk_in, .resetn_in, .ce_in, .phy(phy),
      .mem_rdata_in, .mem_wr_out, .mem_rd_out, .mem_wdata_out,
      .mem_wdata_en_out, .mem_dqs_out, .mem_col_out);
   // Second pair with three-cycle correction delay, fed the same requests
   dcls_ctrl #(.ECC_MODE(2'h3)) dcls_ctrl_e3_i (.mclk_in, .resetn_in,
      .ce_in, .write_req_in, .read_req_in, .size_in, .addr_in,
      .wdata_in, .ready_out(), .rdata_valid_out(e3_valid),
      .rdata_out(e3_rdata), .phy(phy_e3));
   dcls_phy dcls_phy_e3_i (.mclk_in, .resetn_in, .ce_in, .phy(phy_e3),
      .mem_rdata_in, .mem_wr_out(), .mem_rd_out(), .mem_wdata_out(),
      .mem_wdata_en_out(), .mem_dqs_out(), .mem_col_out());
   // Third pair with one-cycle correction delay, fed the same requests
   dcls_ctrl #(.ECC_MODE(2'h1)) dcls_ctrl_e1_i (.mclk_in, .resetn_in,
      .ce_in, .write_req_in, .read_req_in, .size_in, .addr_in,
      .wdata_in, .ready_out(), .rdata_valid_out(e1_valid),
      .rdata_out(e1_rdata), .phy(phy_e1));
   dcls_phy dcls_phy_e1_i (.mclk_in, .resetn_in, .ce_in, .phy(phy_e1),
      .mem_rdata_in, .mem_wr_out(), .mem_rd_out(), .mem_wdata_out(),
      .mem_wdata_en_out(), .mem_dqs_out(), .mem_col_out());
   dcls_monitor dcls_monitor_i (.mclk_in, .resetn_in, .cmd(phy.cmd),
      .col(phy.col), .burst(phy.burst), .wdata_valid(phy.wdata_valid),
      .wmask(phy.wmask), .dqs_burst(phy.dqs_burst),
      .doing_rd(phy.doing_rd), .rdata_valid(phy.rdata_valid));
   // ----------------------------------------------------------------
   // Clock, pin data and traffic log
   // ----------------------------------------------------------------
   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end
   // Pin data changes every cycle so a stale or shifted word shows up
   always @(negedge mclk_in) begin
      cyc = cyc + 1;
      if (phy.cmd !== DCLS_CMD_NOP)
         cmd_q.push_back({phy.cmd, phy.bank, phy.row, phy.col});
      if (phy.wdata_valid === 1'b1) wd_q.push_back(phy.wdata);
      if (phy.doing_rd === 1'b1) rd_win++;
      if (rdata_valid_out === 1'b1) rv_q.push_back({cyc, rdata_out});
      if (e3_valid === 1'b1) e3_q.push_back({cyc, e3_rdata});
      if (e1_valid === 1'b1) e1_q.push_back({cyc, e1_rdata});
      if (mem_wr_out === 1'b1 || mem_rd_out === 1'b1)
         mc_q.push_back({mem_wr_out, mem_col_out});
      if (mem_wdata_en_out === 1'b1 && mem_dqs_out === 1'b1)
         mw_q.push_back(mem_wdata_out);
      mem_rdata_in = {16'ha5c3, cyc[15:0]};
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Held unchanged until ready is seen, so a refused request is retried
   task automatic req(input logic wr, input logic [2:0] sz,
      input logic [23:0] ad, input logic [31:0] wd);
      write_req_in = wr;
      read_req_in = !wr;
      size_in = sz;
      addr_in = ad;
      wdata_in = wd;
      for (int n = 0; n < 200 && ready_out !== 1'b1; n++) begin
         stalls++;
         @(negedge mclk_in);
      end
      check(64'(ready_out === 1'b1), 64'h1);
      @(negedge mclk_in);
   endtask
   // Clears strobes, then waits for sixteen quiet cycles, bounded
   task automatic drain();
      int q;
      q = 0;
      write_req_in = 1'b0;
      read_req_in = 1'b0;
      for (int n = 0; n < 400 && q < 16; n++) begin
         @(negedge mclk_in);
         q = (phy.cmd === DCLS_CMD_NOP && phy.doing_rd !== 1'b1 &&
            rdata_valid_out !== 1'b1 && e3_valid !== 1'b1 &&
            e1_valid !== 1'b1 &&
            phy.wdata_valid !== 1'b1) ? q + 1 : 0;
      end
      check(64'(q), 64'h10);
   endtask
   task automatic clr();
      cmd_q.delete();
      wd_q.delete();
      rv_q.delete();
      e3_q.delete();
      e1_q.delete();
      mc_q.delete();
      mw_q.delete();
      rd_win = 0;
      stalls = 0;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic raw_order();
      clr();
      req(1'b1, 3'h1, 24'h000002, 32'hc0de0001);
      req(1'b0, 3'h1, 24'h000002, 32'h0);
      drain();
      check(64'(cmd_q.size()), 64'h2);
      check(64'(cmd_q[0]), {36'h0, DCLS_CMD_WR, 26'h8});
      check(64'(cmd_q[1]), {36'h0, DCLS_CMD_RD, 26'h8});
      check(64'(wd_q.size()), 64'h1);
      check(64'(wd_q[0]), 64'hc0de0001);
      check(64'(rv_q.size()), 64'h1);
      check(64'(mc_q.size()), 64'h2);
      check(64'(mc_q[0]), 64'h408);
      check(64'(mc_q[1]), 64'h8);
      check(64'(mw_q.size()), 64'h1);
      check(64'(mw_q[0]), 64'hc0de0001);
   endtask
   // Long bursts pop slowly so the four-deep queue must fill
   task automatic fill();
      clr();
      for (int i = 0; i < 6; i++) begin
         req(1'b1, 3'h7, 24'h000100 + 24'(i), 32'hbeef0000 + 32'(i));
      end
      drain();
      check(64'(stalls != 0), 64'h1);
      check(64'(cmd_q.size()), 64'h6);
      check(64'(wd_q.size()), 64'h2a);
      check(64'(wd_q[41]), 64'hbeef0005);
      check(64'(mw_q.size()), 64'h2a);
      check(64'(cmd_q[5]), {36'h0, DCLS_CMD_WR, 26'h414});
   endtask
   task automatic rd_path();
      logic [31:0] c;
      clr();
      req(1'b0, 3'h3, 24'hc01234, 32'h0);
      drain();
      check(64'(cmd_q[0]), {36'h0, DCLS_CMD_RD, 26'h30048d0});
      check(64'(rd_win), 64'h3);
      check(64'(rv_q.size()), 64'h3);
      check(64'(e3_q.size()), 64'h3);
      check(64'(e1_q.size()), 64'h3);
      for (int i = 0; i < 3; i++) begin
         // Pin word passes two sync flops and the capture flop
         c = rv_q[i][63:32] - 32'h3;
         check(rv_q[i][31:0], {16'ha5c3, c[15:0]});
         check(e3_q[i], rv_q[i] + 64'h300000000);
         check(e1_q[i], rv_q[i] + 64'h100000000);
      end
   endtask
   // A request made while the clock enable is low must not be taken
   task automatic ce_hold();
      clr();
      ce_in = 1'b0;
      write_req_in = 1'b1;
      read_req_in = 1'b0;
      size_in = 3'h1;
      addr_in = 24'h000004;
      wdata_in = 32'h5a5a0004;
      repeat (4) @(negedge mclk_in);
      check(64'(cmd_q.size()), 64'h0);
      check(64'(ready_out), 64'h1);
      ce_in = 1'b1;
      @(negedge mclk_in);
      drain();
      check(64'(cmd_q.size()), 64'h1);
      check(64'(wd_q[0]), 64'h5a5a0004);
   endtask
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      resetn_in = 1'b0;
      write_req_in = 1'b0;
      read_req_in = 1'b0;
      size_in = 3'h0;
      addr_in = 24'h0;
      wdata_in = 32'h0;
      ce_in = 1'b1;
      repeat (8) @(negedge mclk_in);
      resetn_in = 1'b1;
      @(negedge mclk_in);
      raw_order();
      fill();
      rd_path();
      ce_hold();
      give_verdict();
   end
   // Whole run is a few hundred cycles; this span is ample
   initial begin
      #40000;
      error_cnt++;
      give_verdict();
   end
endmodule
